// File: rtl/sti_pkg.sv
// Constants, register map and carrier types for the safe torque interlock.
// Assumes an APB master on the 20 MHz control clock.
package sti_pkg;
	localparam logic [11:0] ADDR_LATCH_SEL = 12'h000;
	localparam logic [11:0] ADDR_CTRL      = 12'h004;
	localparam logic [11:0] ADDR_STATUS    = 12'h008;
	localparam logic [11:0] ADDR_IRQ_STAT  = 12'h00C;
	localparam logic [11:0] ADDR_IRQ_MASK  = 12'h010;
	localparam logic [11:0] ADDR_HISTORY   = 12'h014;
	localparam logic [15:0] LATCH_SEL_RST  = 16'h0000;
	localparam int          CTRL_RESTART   = 0;
	localparam int          CTRL_RESET_CMD = 1;
	localparam logic [7:0]  CODE_CH_A      = 8'h48; // 72
	localparam logic [7:0]  CODE_CUT       = 8'h4C; // 76
	localparam logic [7:0]  CODE_CH_B      = 8'h4D; // 77
	localparam logic [7:0]  CODE_INTERNAL  = 8'h4E; // 78
	localparam int          CLK_HZ         = 20000000;
	localparam int          STOP_MS        = 20;
	localparam int          STOP_CYC       = CLK_HZ / 1000 * STOP_MS;
	localparam int          HIST_DEPTH     = 6;
	// Cycles a changed channel pair must hold before it is classified
	localparam int          SKEW_CYC       = 4;

	typedef struct packed {
		logic cut;
		logic ch_a;
		logic ch_b;
		logic internal;
	} fault_t;

	typedef enum logic [3:0] {
		ST_READY = 4'b0001,
		ST_CUT   = 4'b0010,
		ST_LOOP  = 4'b0100,
		ST_WAIT  = 4'b1000
	} state_t;
endpackage : sti_pkg

// File: rtl/safe_torque_interlock.sv
// Dual-channel torque interlock with APB registers and fault history.
// Assumes safety inputs and run command are synchronous-ish levels; the
// channels and run are double-flopped here anyway, the diag error once.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module safe_torque_interlock
	import sti_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RESET,
	// Safety and control inputs (high = channel on)
	input  wire logic        I_SAFETY_CHANNEL_A_INPUT,
	input  wire logic        I_SAFETY_CHANNEL_B_INPUT,
	input  wire logic        I_INT_DIAG_ERR,
	input  wire logic        I_RUN_CMD,
	// APB slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// Drive outputs
	output logic             O_POWER_SWITCH_GATING,
	output logic       [3:0] O_FAULT_DISPLAY,
	output logic             O_IRQ
);
	// Synchroniser stages; first stage read only by the second
	logic [1:0]  sa_q, sb_q, run_q;
	logic        diag_q;
	logic        a_on, b_on, run_s, run_prev_q;
	// Debounce of channel skew: classify only after inputs settle
	logic [2:0]  skew_q;
	logic        a_cls_q, b_cls_q;
	state_t      state_q, state_d;
	fault_t      fault_q, fault_d, irq_stat_q, irq_mask_q;
	logic [15:0] latch_sel_q;
	logic        restart_q, reset_cmd;
	logic [7:0]  hist_q [HIST_DEPTH];
	logic        gate_d;

	// Two-flop synchronisers for the channel and run levels; one flop for diag
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			sa_q   <= 2'h0;
			sb_q   <= 2'h0;
			run_q  <= 2'h0;
			diag_q <= 1'b0;
		end else begin
			sa_q   <= {sa_q[0], I_SAFETY_CHANNEL_A_INPUT};
			sb_q   <= {sb_q[0], I_SAFETY_CHANNEL_B_INPUT};
			run_q  <= {run_q[0], I_RUN_CMD};
			diag_q <= I_INT_DIAG_ERR;
		end
	end
	assign a_on  = sa_q[1];
	assign b_on  = sb_q[1];
	assign run_s = run_q[1];

	// Hold the classified pair until the synced pair has differed from it for SKEW_CYC cycles,
	// so a skewed e-stop opening is not taken as a single-channel fault.
	// Gating itself is dropped at once, independent of this filter.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			skew_q  <= 3'h0;
			a_cls_q <= 1'b1;
			b_cls_q <= 1'b1;
		end else if (a_on == a_cls_q && b_on == b_cls_q) begin
			skew_q <= 3'h0;
		end else if (skew_q == 3'(SKEW_CYC - 1)) begin
			skew_q  <= 3'h0;
			a_cls_q <= a_on;
			b_cls_q <= b_on;
		end else begin
			skew_q <= skew_q + 3'h1;
		end
	end

	// Software reset command is a self-clearing control bit
	assign reset_cmd = I_PSEL && I_PENABLE && I_PWRITE
		&& I_PADDR == ADDR_CTRL && I_PWDATA[CTRL_RESET_CMD];

	// Fault classification and latching
	always_comb begin
		fault_d = fault_q;
		state_d = state_q;
		if (diag_q)
			fault_d.internal = 1'b1;
		if (!a_cls_q && b_cls_q)
			fault_d.ch_a = 1'b1;
		if (a_cls_q && !b_cls_q)
			fault_d.ch_b = 1'b1;
		if (!a_cls_q && !b_cls_q)
			fault_d.cut = 1'b1;
		else if (a_cls_q && b_cls_q && fault_q.cut) begin
			// 0 waits for reset, 1 clears at once
			if (latch_sel_q[0] || reset_cmd)
				fault_d.cut = 1'b0;
		end
		// loop faults have no clear path except I_RESET
		case (state_q)
			ST_READY: begin
				if (fault_d.ch_a || fault_d.ch_b || fault_d.internal)
					state_d = ST_LOOP;
				else if (fault_d.cut)
					state_d = ST_CUT;
			end
			ST_CUT: begin
				if (fault_d.ch_a || fault_d.ch_b || fault_d.internal)
					state_d = ST_LOOP;
				else if (!fault_d.cut) begin
					// self-clear or no restart needs run re-edge
					if (!latch_sel_q[0] && restart_q)
						state_d = ST_READY;
					else
						state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (fault_d.ch_a || fault_d.ch_b || fault_d.internal)
					state_d = ST_LOOP;
				else if (fault_d.cut)
					state_d = ST_CUT;
				else if (!run_s)
					state_d = ST_READY;
			end
			ST_LOOP: state_d = ST_LOOP;
			default: state_d = ST_LOOP;
		endcase
	end

	// gate only when ready, both raw synced inputs on, run on
	assign gate_d = state_d == ST_READY && a_on && b_on && run_s
		&& !diag_q;

	// State, faults and drive outputs
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			state_q               <= ST_READY;
			fault_q               <= '0;
			run_prev_q            <= 1'b0;
			O_POWER_SWITCH_GATING <= 1'b0;
			O_FAULT_DISPLAY       <= 4'h0;
		end else begin
			state_q               <= state_d;
			fault_q               <= fault_d;
			run_prev_q            <= run_s;
			O_POWER_SWITCH_GATING <= gate_d;
			O_FAULT_DISPLAY       <= fault_d;
		end
	end

	// Fault history: newest code at slot 0, one code pushed per cycle in which a fault bit rises
	logic [3:0] fault_rise;
	logic [7:0] new_code;
	assign fault_rise = fault_d & ~fault_q;
	assign new_code = fault_rise[3] ? CODE_CUT :
		fault_rise[2] ? CODE_CH_A :
		fault_rise[1] ? CODE_CH_B : CODE_INTERNAL;
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			for (int i = 0; i < HIST_DEPTH; i++)
				hist_q[i] <= 8'h00;
		end else if (|fault_rise) begin
			hist_q[0] <= new_code;
			for (int i = 1; i < HIST_DEPTH; i++)
				hist_q[i] <= hist_q[i-1];
		end
	end

	// Interrupt status: set beats write-one-to-clear; a mask bit of one
	// silences its source, so after reset every source is heard
	logic apb_wr;
	fault_t w1c;
	assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
	assign w1c = (apb_wr && I_PADDR == ADDR_IRQ_STAT) ? I_PWDATA[3:0] : '0;
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			latch_sel_q <= LATCH_SEL_RST;
			restart_q  <= 1'b0;
			O_IRQ      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~w1c) | fault_rise;
			if (apb_wr && I_PADDR == ADDR_IRQ_MASK)
				irq_mask_q <= I_PWDATA[3:0];
			if (apb_wr && I_PADDR == ADDR_LATCH_SEL)
				latch_sel_q <= I_PWDATA[15:0];
			if (apb_wr && I_PADDR == ADDR_CTRL)
				restart_q <= I_PWDATA[CTRL_RESTART];
			O_IRQ <= |(((irq_stat_q & ~w1c) | fault_rise) & ~irq_mask_q);
		end
	end

	// APB read mux; one wait-free access, unmapped reads zero with error
	logic [31:0] rd_d;
	logic        hit;
	assign hit = I_PADDR == ADDR_LATCH_SEL || I_PADDR == ADDR_CTRL
		|| I_PADDR == ADDR_STATUS || I_PADDR == ADDR_IRQ_STAT
		|| I_PADDR == ADDR_IRQ_MASK || I_PADDR == ADDR_HISTORY;
	always_comb begin
		case (I_PADDR)
			ADDR_LATCH_SEL: rd_d = {16'h0000, latch_sel_q};
			ADDR_CTRL:      rd_d = {31'h0, restart_q};
			ADDR_STATUS:    rd_d = {20'h0, state_q, 3'h0,
				O_POWER_SWITCH_GATING, fault_q};
			ADDR_IRQ_STAT:  rd_d = {28'h0, irq_stat_q};
			ADDR_IRQ_MASK:  rd_d = {28'h0, irq_mask_q};
			ADDR_HISTORY:   rd_d = {hist_q[3], hist_q[2], hist_q[1],
				hist_q[0]};
			default:        rd_d = 32'h0;
		endcase
	end
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_PRDATA  <= 32'h0;
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= I_PSEL && !I_PENABLE;
			O_PRDATA  <= (I_PSEL && !I_PENABLE) ? rd_d : O_PRDATA;
			O_PSLVERR <= I_PSEL && !I_PENABLE && !hit;
		end
	end

	// Checks. A drop on either synced channel must cut gating within two
	// edges; the skew filter sits only on the fault classification.
	sequence chan_drop_s;
		$fell(sa_q[1]) || $fell(sb_q[1]);
	endsequence
	sequence gate_off_s;
		##[1:2] !O_POWER_SWITCH_GATING;
	endsequence
	// A settled pair is followed one edge later by its latched fault
	sequence both_off_s;
		!a_cls_q && !b_cls_q;
	endsequence
	sequence cut_shown_s;
		##1 (fault_q.cut && O_FAULT_DISPLAY[3]);
	endsequence
	stop_time_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		$fell(sa_q[1]) |-> ##[1:2] !O_POWER_SWITCH_GATING)
		else $error("gating not cut after channel A drop");
	drop_stop_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		chan_drop_s |-> gate_off_s)
		else $error("gating not cut after a channel drop");
	loop_sticky_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		fault_q.ch_a |=> fault_q.ch_a)
		else $error("channel A fault cleared without power reset");
	cut_gate_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		fault_q.cut |-> !O_POWER_SWITCH_GATING)
		else $error("gating during safe torque cut");
	latch_hold_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		fault_q.cut && !latch_sel_q[0] && !reset_cmd |=> fault_q.cut)
		else $error("latched cut alarm cleared without reset");
	internal_flag_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		diag_q |=> fault_q.internal)
		else $error("internal fault not flagged");
	rerun_wait_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		state_q == ST_WAIT |-> !O_POWER_SWITCH_GATING)
		else $error("output resumed without run re-edge");
	hist_code_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		$rose(fault_q.ch_b) && !fault_rise[3] && !$past(fault_rise[3])
		&& !$past(fault_rise[2]) |-> hist_q[0] == CODE_CH_B)
		else $error("wrong history code for channel B");
	auto_clear_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		fault_q.cut && latch_sel_q[0] && a_cls_q && b_cls_q |=>
		!fault_q.cut)
		else $error("non-latching cut alarm did not clear");
	cut_class_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		both_off_s |-> cut_shown_s)
		else $error("both channels off but cut fault not shown");
	chan_a_fault_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		!a_cls_q && b_cls_q |=> fault_q.ch_a && O_FAULT_DISPLAY[2])
		else $error("channel A loop fault not shown");
	chan_b_fault_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		a_cls_q && !b_cls_q |=> fault_q.ch_b && O_FAULT_DISPLAY[1])
		else $error("channel B loop fault not shown");
	// In ST_READY with both channels on, no diag error and nothing latched, gating follows run
	run_follow_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		state_q == ST_READY && !(|fault_q) && a_cls_q && b_cls_q && a_on
		&& b_on && run_s && !diag_q |=> O_POWER_SWITCH_GATING
		&& O_FAULT_DISPLAY == 4'h0)
		else $error("gating or display wrong in normal running");
	run_stop_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		!run_s |=> !O_POWER_SWITCH_GATING)
		else $error("gating without a run command");
	loop_hold_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		state_q == ST_LOOP |=> state_q == ST_LOOP
		&& !O_POWER_SWITCH_GATING)
		else $error("loop fault state left or gating resumed");
	hist_cut_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		$rose(fault_q.cut) |-> hist_q[0] == CODE_CUT)
		else $error("wrong history code for safe torque cut");
	// An unmasked pending source that nobody clears keeps the line up
	irq_level_a: assert property (
		@(posedge I_CLK) disable iff (I_RESET)
		|(irq_stat_q & ~irq_mask_q) && !apb_wr |=> O_IRQ)
		else $error("interrupt line low with unmasked status set");
endmodule : safe_torque_interlock
`default_nettype wire

// File: verif/emergency_stop_switch_switch_model.sv
// Emergency stop switch model: two contacts feeding the safety channels.
// Assumes the bench commands each contact open or closed on a clock edge.
`timescale 1ns/100ps
`default_nettype none
module emergency_stop_switch_switch_model (
	// Clock and commands
	input  wire logic i_clk,
	input  wire logic i_open_a,
	input  wire logic i_open_b,
	// Contact levels, high means closed
	output logic      o_chan_a,
	output logic      o_chan_b
);
	// Open commands as last sampled; contacts start closed so the drive
	// powers up with both channels on. One driver per contact level.
	logic open_a_q = 1'b0;
	logic open_b_q = 1'b0;
	// Each contact follows its command one edge later, no bounce
	always @(posedge i_clk) begin
		open_a_q <= i_open_a;
		open_b_q <= i_open_b;
	end
	assign o_chan_a = !open_a_q;
	assign o_chan_b = !open_b_q;
endmodule : emergency_stop_switch_switch_model
`default_nettype wire

// File: verif/safe_torque_interlock_bench.sv
// Self-checking bench for the torque interlock: APB master and switch.
// Assumes one 20 MHz clock and an APB slave that answers when it is ready.
`timescale 1ns/100ps
`default_nettype none
module safe_torque_interlock_bench;
	import sti_pkg::*;
	logic        clk = 0, rst = 1, open_a = 0, open_b = 0;
	logic        diag = 0, run = 0, psel = 0, pen = 0, pwr = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, perr, gate, irq, cha, chb;
	logic [3:0]  disp;
	int          fail_count = 0, total_checks = 0, cycles = 0;
	// Clock and a cycle ceiling that cuts a hang short
	always #25 clk = !clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			end_sim();
		end
	end
	emergency_stop_switch_switch_model i_sw (.i_clk(clk), .i_open_a(open_a),
		.i_open_b(open_b), .o_chan_a(cha), .o_chan_b(chb));
	safe_torque_interlock i_dut (.I_CLK(clk), .I_RESET(rst),
		.I_SAFETY_CHANNEL_A_INPUT(cha), .I_SAFETY_CHANNEL_B_INPUT(chb),
		.I_INT_DIAG_ERR(diag), .I_RUN_CMD(run), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(perr), .O_POWER_SWITCH_GATING(gate),
		.O_FAULT_DISPLAY(disp), .O_IRQ(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	// Power cycle: reset stands for five clock edges
	task automatic power_cycle();
		rst <= 1'b1;
		cyc(5);
		rst <= 1'b0;
	endtask : power_cycle
	task automatic set_sw(input logic a, input logic b, input logic e);
		open_a <= a;
		open_b <= b;
		diag <= e;
		cyc(12);
	endtask : set_sw
	task automatic t_regs_and_run();
		apb(0, ADDR_LATCH_SEL, 0);
		chk(r, 32'h0);
		apb(0, 12'hFFC, 0);
		chk(perr, 1'b1);
		run <= 1'b1;
		cyc(10);
		chk(gate, 1'b1);
		chk(disp, 4'h0);
		run <= 1'b0;
		cyc(6);
		chk(gate, 1'b0);
		run <= 1'b1;
		cyc(6);
		chk(gate, 1'b1);
	endtask : t_regs_and_run
	// Latching cut with interrupt raised, masked and cleared
	task automatic t_cut_latch();
		set_sw(1, 1, 0);
		chk(gate, 1'b0);
		chk(disp, 4'h8);
		chk(irq, 1'b1);
		apb(0, ADDR_IRQ_STAT, 0);
		chk(r[3:0], 4'h8);
		apb(1, ADDR_IRQ_MASK, 32'hF);
		cyc(3);
		chk(irq, 1'b0);
		set_sw(0, 0, 0);
		chk(disp, 4'h8);
		apb(1, ADDR_CTRL, 32'h2);
		cyc(4);
		chk(disp, 4'h0);
		chk(gate, 1'b0);
		apb(0, ADDR_HISTORY, 0);
		chk(r[7:0], CODE_CUT);
		apb(1, ADDR_IRQ_STAT, 32'hF);
		apb(1, ADDR_IRQ_MASK, 32'h0);
		cyc(3);
		chk(irq, 1'b0);
	endtask : t_cut_latch
	// Self-clearing cut; output needs a fresh run command
	task automatic t_cut_auto();
		apb(1, ADDR_LATCH_SEL, 32'h1);
		apb(0, ADDR_LATCH_SEL, 0);
		chk(r, 32'h1);
		set_sw(1, 1, 0);
		chk(disp, 4'h8);
		set_sw(0, 0, 0);
		chk(disp, 4'h0);
		chk(gate, 1'b0);
		run <= 1'b0;
		cyc(6);
		run <= 1'b1;
		cyc(6);
		chk(gate, 1'b1);
	endtask : t_cut_auto
	// Loop faults survive recovery and a reset command, even unlatched
	task automatic t_loop(input logic a, input logic b, input logic e,
		input logic [3:0] exp, input logic [7:0] code);
		apb(1, ADDR_LATCH_SEL, 32'h1);
		set_sw(a, b, e);
		chk(gate, 1'b0);
		chk(disp, exp);
		apb(0, ADDR_STATUS, 0);
		chk(r[11:0], {ST_LOOP, 3'h0, 1'b0, exp});
		apb(0, ADDR_HISTORY, 0);
		chk(r[7:0], code);
		set_sw(0, 0, 0);
		apb(1, ADDR_CTRL, 32'h2);
		cyc(4);
		chk(disp, exp);
		power_cycle();
		cyc(2);
		chk(disp, 4'h0);
	endtask : t_loop
	task automatic t_restart();
		apb(1, ADDR_CTRL, 32'h1);
		set_sw(1, 1, 0);
		set_sw(0, 0, 0);
		apb(1, ADDR_CTRL, 32'h3);
		cyc(4);
		chk(gate, 1'b1);
	endtask : t_restart
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		power_cycle();
		t_regs_and_run();
		t_cut_latch();
		t_cut_auto();
		t_loop(1, 0, 0, 4'h4, CODE_CH_A);
		t_loop(0, 1, 0, 4'h2, CODE_CH_B);
		t_loop(0, 0, 1, 4'h1, CODE_INTERNAL);
		t_restart();
		end_sim();
	end
endmodule : safe_torque_interlock_bench
`default_nettype wire
